/* File: core/hada_pkg.sv */
// Shared constants, register map and helper functions of the audio DMA.
// Assumes a 32-bit register bus in which each register takes one word.
package hada_pkg;

   // Register indices; the byte address is four times the index
   localparam logic [31:0] IDX_BURST_CFG = 32'h0012_3600;
   localparam logic [31:0] IDX_CONTROL   = 32'h0012_3601;
   localparam logic [31:0] IDX_STATUS    = 32'h0012_3602;
   localparam logic [31:0] IDX_THRESHOLD = 32'h0012_3603;
   localparam logic [31:0] IDX_FIRST     = 32'h0012_3604;
   localparam logic [31:0] IDX_LAST      = 32'h0012_3605;
   localparam logic [31:0] IDX_CHANNELS  = 32'h0012_3606;
   localparam logic [31:0] IDX_ACR_N     = 32'h0012_3607;
   localparam logic [31:0] IDX_ACR_CTS   = 32'h0012_3608;
   localparam logic [31:0] IDX_INT_STAT  = 32'h0012_3609;
   localparam logic [31:0] IDX_INT_MASK  = 32'h0012_360A;

   // Field positions
   localparam int CFG_SINGLE   = 0;
   localparam int CFG_TYPE_LSB = 1;
   localparam int CTRL_START   = 0;
   localparam int CTRL_STOP    = 1;
   localparam int STAT_PRIMED  = 16;
   localparam int STAT_RUN     = 17;
   localparam int STAT_BUSY    = 18;
   localparam int INT_DONE     = 0;
   localparam int INT_EMPTY    = 1;
   localparam int INT_FULL     = 2;
   localparam int INT_ERROR    = 3;
   localparam int INT_W        = 4;

   // Reset values
   localparam logic [7:0] CFG_RST  = 8'h00;
   localparam logic [7:0] THR_RST  = 8'h7E;
   localparam logic [3:0] CHAN_RST = 4'h2;

   // Bus encodings
   localparam logic [1:0] HTRANS_IDLE   = 2'h0;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HTRANS_SEQ    = 2'h3;
   localparam logic [2:0] HBURST_SINGLE = 3'h0;
   localparam logic [2:0] HBURST_INCR   = 3'h1;
   localparam logic [2:0] HBURST_INCR4  = 3'h3;
   localparam logic [2:0] HBURST_INCR8  = 3'h5;
   localparam logic [2:0] HBURST_INCR16 = 3'h7;
   localparam logic [2:0] HSIZE_WORD    = 3'h2;
   localparam logic [4:0] INCR_ANY_BEATS = 5'h08;

   typedef enum logic [1:0] {
      INCR_ANY = 2'b00,
      INCR_4   = 2'b01,
      INCR_8   = 2'b10,
      INCR_16  = 2'b11
   } hada_incr_t;

   typedef enum logic [1:0] {
      DMA_IDLE = 2'b00,
      DMA_ADDR = 2'b01,
      DMA_DATA = 2'b10
   } hada_dma_t;

   // Beats of one fetch for a burst configuration
   function automatic logic [4:0] hada_beats(input logic [7:0] cfg);
      hada_incr_t t;
      logic [4:0] b;
      t = hada_incr_t'(cfg[CFG_TYPE_LSB +: 2]);
      unique case (t)
         INCR_ANY: b = INCR_ANY_BEATS;
         INCR_4:   b = 5'h04;
         INCR_8:   b = 5'h08;
         INCR_16:  b = 5'h10;
      endcase
      if (cfg[CFG_SINGLE]) b = 5'h01;
      return b;
   endfunction

   // Burst code for a burst configuration
   function automatic logic [2:0] hada_burst_code(input logic [7:0] cfg);
      hada_incr_t t;
      logic [2:0] c;
      t = hada_incr_t'(cfg[CFG_TYPE_LSB +: 2]);
      unique case (t)
         INCR_ANY: c = HBURST_INCR;
         INCR_4:   c = HBURST_INCR4;
         INCR_8:   c = HBURST_INCR8;
         INCR_16:  c = HBURST_INCR16;
      endcase
      if (cfg[CFG_SINGLE]) c = HBURST_SINGLE;
      return c;
   endfunction

endpackage

/* File: core/hada_fifo_if.sv */
// Carrier between the DMA engine and its sample FIFO.
// Assumes both ends share one clock.
`timescale 1ns/100ps
`default_nettype none
interface hada_fifo_if #(parameter int W = 32, parameter int AW = 7);
   logic          push;
   logic [W-1:0]  push_data;
   logic          pop;
   logic          flush;
   logic [W-1:0]  pop_data;
   logic [AW:0]   level;
   logic          full;
   logic          underflow;
   modport fill  (output push, push_data, pop, flush,
                  input pop_data, level, full, underflow);
   modport store (input push, push_data, pop, flush,
                  output pop_data, level, full, underflow);
endinterface
`default_nettype wire

/* File: core/hada_fifo.sv */
// Audio sample FIFO of the DMA engine, with last-sample repeat.
// Assumes the filling side never pushes while full.
`timescale 1ns/100ps
`default_nettype none
module hada_fifo import hada_pkg::*; #(
   parameter int W  = 32,
   parameter int AW = 7
) (
   // System
   input  wire logic clk_sys,
   input  wire logic rst_n,
   input  wire logic ce,
   // Sample store
   hada_fifo_if.store f
);
   localparam int DEPTH = 1 << AW;

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0]           wp;
      logic [AW-1:0]           rp;
      logic [AW:0]             cnt;
      logic [W-1:0]            dout;
      logic                    unf;
   } hada_fifo_st_t;

   hada_fifo_st_t r;
   hada_fifo_st_t n;

   always_comb begin
      logic wr_ok;
      logic rd_ok;
      wr_ok = f.push && (r.cnt != (AW+1)'(DEPTH));
      rd_ok = f.pop && (r.cnt != '0);
      n = r;
      n.unf = f.pop && (r.cnt == '0);
      if (f.flush) begin
         n.wp = '0;
         n.rp = '0;
         n.cnt = '0;
      end else begin
         if (wr_ok) begin
            n.mem[r.wp] = f.push_data;
            n.wp = r.wp + 1'b1;
         end
         // Empty read keeps the last sample on the output
         if (rd_ok) begin                                          // R6
            n.dout = r.mem[r.rp];
            n.rp = r.rp + 1'b1;
         end
         n.cnt = r.cnt + (AW+1)'(wr_ok) - (AW+1)'(rd_ok);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         r <= '0;
      end else if (ce) begin
         r <= n;
      end
   end

   assign f.pop_data  = r.dout;
   assign f.level     = r.cnt;
   assign f.full      = (r.cnt == (AW+1)'(DEPTH));
   assign f.underflow = r.unf;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   a_repeat_last: assert property (                                // R6
      (ce && f.pop && r.cnt == '0 && !f.flush) |=> $stable(r.dout) && r.unf)
      else $error("empty read did not repeat last sample");
   a_fifo_bound: assert property (r.cnt <= (AW+1)'(DEPTH))
      else $error("fifo count beyond depth");

endmodule // hada_fifo
`default_nettype wire

/* File: core/hada_audio_dma.sv */
// Audio DMA engine: register slave, burst fetch master, sample FIFO.
// Assumes one clock; both buses are AHB-Lite on that clock.
`timescale 1ns/100ps
`default_nettype none
// Operation
// R1: threshold field gates new fetch requests
// R2: bits 2:1 select incrementing burst type
// R3: stereo: threshold 126, unspecified-length bursts
// R4: multichannel: threshold 126, four-beat bursts
// R5: start bit begins filling the FIFO
// R6: empty FIFO repeats its last sample
// R7: buffer length multiple of channel count
// R8: start: zero N, start, wait full
// R9: underflow flags empty; software restarts
// R10: zero N register gives null N
// R11: init: zero N, then write CTS
// R12: first read waits for channel-count samples
// R13: stop ends fetching, raises done flag
// R14: fetch spans first to last address
module hada_audio_dma import hada_pkg::*; #(
   parameter int AW = 7
) (
   // System
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   input  wire logic        ce,
   // Register slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // Fetch master
   output logic [31:0]      m_haddr,
   output logic [1:0]       m_htrans,
   output logic [2:0]       m_hburst,
   output logic [2:0]       m_hsize,
   output logic             m_hwrite,
   input  wire logic [31:0] m_hrdata,
   input  wire logic        m_hready,
   input  wire logic        m_hresp,
   // Audio sample path
   input  wire logic        aud_rd,
   output logic [31:0]      aud_data,
   output logic             aud_primed,
   // Clock regeneration values
   output logic [23:0]      acr_n,
   output logic [23:0]      acr_cts,
   // Interrupt
   output logic             irq
);
   localparam int DEPTH = 1 << AW;

   typedef struct packed {
      logic             wr_pend;
      logic [29:0]      wr_idx;
      logic             rd_pend;
      logic [29:0]      rd_idx;
      logic             hready_o;
      logic [31:0]      hrdata;
      logic [7:0]       cfg;
      logic [7:0]       thr;
      logic             run;
      logic             start_req;
      logic             stop_req;
      logic [31:0]      first;
      logic [31:0]      last;
      logic [3:0]       chans;
      logic [23:0]      n_val;
      logic [23:0]      cts_val;
      logic [INT_W-1:0] ist;
      logic [INT_W-1:0] imask;
      logic             irq;
      hada_dma_t        st;
      logic [31:0]      addr;
      logic [31:0]      m_haddr;
      logic [1:0]       m_htrans;
      logic [2:0]       m_hburst;
      logic [4:0]       to_issue;
      logic             dph;
      logic             end_hit;
      logic             err;
      logic             primed;
      logic             full_d;
   } hada_state_t;

   hada_state_t r;
   hada_state_t n;

   hada_fifo_if #(.W(32), .AW(AW)) f ();

   hada_fifo #(.W(32), .AW(AW)) u_fifo (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .ce      (ce),
      .f       (f)
   );

   assign f.push_data = m_hrdata;

   always_comb begin
      logic [INT_W-1:0] ev;
      logic [INT_W-1:0] clr;
      logic [4:0]       b;
      logic [31:0]      rem;
      logic             take;
      ev = '0;
      clr = '0;
      b = hada_beats(r.cfg);
      rem = r.last - r.addr;
      take = 1'b0;
      n = r;
      f.push = 1'b0;
      f.flush = 1'b0;
      f.pop = aud_rd && r.primed;                                  // R12

      // Register write in its data phase
      if (r.wr_pend) begin
         case (r.wr_idx)
            IDX_BURST_CFG[29:0]: n.cfg = hwdata[7:0];             // R2
            IDX_THRESHOLD[29:0]: n.thr = hwdata[7:0];             // R1
            IDX_CONTROL[29:0]: begin
               if (hwdata[CTRL_START]) n.start_req = 1'b1;         // R5
               if (hwdata[CTRL_STOP] && r.run) n.stop_req = 1'b1;  // R13
            end
            IDX_FIRST[29:0]:    n.first = hwdata;                 // R14
            IDX_LAST[29:0]:     n.last = hwdata;                  // R14
            IDX_CHANNELS[29:0]: n.chans = hwdata[3:0];
            IDX_ACR_N[29:0]:    n.n_val = hwdata[23:0];           // R10
            IDX_ACR_CTS[29:0]:  n.cts_val = hwdata[23:0];
            IDX_INT_STAT[29:0]: clr = hwdata[INT_W-1:0];
            IDX_INT_MASK[29:0]: n.imask = hwdata[INT_W-1:0];
            default: ;
         endcase
      end

      // Read data one wait state after the address phase
      if (r.rd_pend) begin
         n.rd_pend = 1'b0;
         n.hready_o = 1'b1;
         case (r.rd_idx)
            IDX_BURST_CFG[29:0]: n.hrdata = {24'h000000, r.cfg};
            IDX_THRESHOLD[29:0]: n.hrdata = {24'h000000, r.thr};
            IDX_CONTROL[29:0]:
               n.hrdata = {30'h00000000, r.stop_req, r.run};
            IDX_STATUS[29:0]: begin
               n.hrdata = 32'(f.level);
               n.hrdata[STAT_PRIMED] = r.primed;
               n.hrdata[STAT_RUN] = r.run;
               n.hrdata[STAT_BUSY] = (r.st != DMA_IDLE);
            end
            IDX_FIRST[29:0]:    n.hrdata = r.first;
            IDX_LAST[29:0]:     n.hrdata = r.last;
            IDX_CHANNELS[29:0]: n.hrdata = {28'h0000000, r.chans};
            IDX_ACR_N[29:0]:    n.hrdata = {8'h00, r.n_val};
            IDX_ACR_CTS[29:0]:  n.hrdata = {8'h00, r.cts_val};
            IDX_INT_STAT[29:0]: n.hrdata = 32'(r.ist);
            IDX_INT_MASK[29:0]: n.hrdata = 32'(r.imask);
            default:            n.hrdata = 32'h00000000;
         endcase
      end

      // Address phase
      n.wr_pend = 1'b0;
      if (hsel && htrans[1] && hready) begin
         if (hwrite) begin
            n.wr_pend = 1'b1;
            n.wr_idx = haddr[31:2];
         end else begin
            n.rd_pend = 1'b1;
            n.rd_idx = haddr[31:2];
            n.hready_o = 1'b0;
         end
      end

      // Fetch master
      unique case (r.st)
         DMA_IDLE: begin
            n.dph = 1'b0;
            if (r.start_req) begin                                 // R5
               n.start_req = 1'b0;
               n.stop_req = 1'b0;
               n.run = 1'b1;
               n.addr = r.first;                                   // R14
               n.end_hit = 1'b0;
               n.err = 1'b0;
               n.primed = 1'b0;
               f.flush = 1'b1;
            end else if (r.run && (r.stop_req || r.end_hit || r.err)) begin
               n.run = 1'b0;                                       // R13
               n.stop_req = 1'b0;
               ev[INT_DONE] = 1'b1;                                // R13
            end else if (r.run
                         && f.level < (AW+1)'(r.thr)               // R1
                         && 32'(f.level) + 32'(b) <= 32'(DEPTH)) begin
               n.m_hburst = hada_burst_code(r.cfg);                // R2
               if (rem[31:2] < 30'(b - 5'h01)) begin
                  b = 5'h01;
                  n.m_hburst = HBURST_SINGLE;
               end
               n.m_haddr = r.addr;
               n.m_htrans = HTRANS_NONSEQ;
               n.to_issue = b - 5'h01;
               n.st = DMA_ADDR;
            end
         end
         DMA_ADDR: begin
            if (m_hready) begin
               take = r.dph;
               n.dph = 1'b1;
               n.addr = r.m_haddr + 32'h00000004;
               if (r.m_haddr == r.last) n.end_hit = 1'b1;          // R14
               if (r.to_issue != 5'h00) begin
                  n.m_haddr = r.m_haddr + 32'h00000004;
                  n.m_htrans = HTRANS_SEQ;
                  n.to_issue = r.to_issue - 5'h01;
               end else begin
                  n.m_htrans = HTRANS_IDLE;
                  n.st = DMA_DATA;
               end
            end
         end
         DMA_DATA: begin
            if (m_hready) begin
               take = 1'b1;
               n.dph = 1'b0;
               n.st = DMA_IDLE;
            end
         end
         default: n.st = DMA_IDLE;
      endcase

      // Beat arrival; error beats are dropped and end the run
      if (take) begin
         if (m_hresp) begin
            n.err = 1'b1;
            ev[INT_ERROR] = 1'b1;
         end else if (!r.err) begin
            f.push = 1'b1;
         end
      end

      // Reads held back until one sample per channel is stored
      if (r.run && !r.primed && !f.flush && r.chans != 4'h0
          && 32'(f.level) >= 32'(r.chans)) begin
         n.primed = 1'b1;                                          // R12
      end

      n.full_d = f.full;
      if (f.full && !r.full_d) ev[INT_FULL] = 1'b1;
      if (f.underflow) ev[INT_EMPTY] = 1'b1;                       // R9

      // Sticky status, set wins over write-one clear
      n.ist = (r.ist & ~clr) | ev;
      n.irq = |(n.ist & n.imask);
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         r <= '0;
         r.hready_o <= 1'b1;
         r.cfg <= CFG_RST;
         r.thr <= THR_RST;
         r.chans <= CHAN_RST;
      end else if (ce) begin
         r <= n;
      end
   end

   assign hreadyout  = r.hready_o;
   assign hresp      = 1'b0;
   assign hrdata     = r.hrdata;
   assign m_haddr    = r.m_haddr;
   assign m_htrans   = r.m_htrans;
   assign m_hburst   = r.m_hburst;
   assign m_hsize    = HSIZE_WORD;
   assign m_hwrite   = 1'b0;
   assign aud_data   = f.pop_data;
   assign aud_primed = r.primed;
   assign acr_n      = r.n_val;
   assign acr_cts    = r.cts_val;
   assign irq        = r.irq;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   a_fetch_below_thr: assert property (                           // R1
      (ce && r.st == DMA_IDLE) ##1 (r.st == DMA_ADDR)
      |-> $past(f.level) < (AW+1)'($past(r.thr)))
      else $error("fetch issued at or above threshold");
   a_burst_type_sel: assert property (                            // R2
      (ce && r.st == DMA_IDLE) ##1 (r.st == DMA_ADDR)
      |-> (r.m_hburst == HBURST_SINGLE
           || r.m_hburst == hada_burst_code($past(r.cfg))))
      else $error("burst type differs from configuration");
   a_start_loads: assert property (                               // R5
      (ce && r.st == DMA_IDLE && r.start_req)
      |=> r.run && r.addr == $past(r.first) && !r.primed)
      else $error("start did not begin a new run");
   a_empty_flag: assert property (                                // R9
      (ce && f.underflow) |=> r.ist[INT_EMPTY])
      else $error("underflow did not set empty flag");
   a_null_n_out: assert property (                                // R10
      (ce && r.wr_pend && r.wr_idx == IDX_ACR_N[29:0]
       && hwdata[23:0] == 24'h000000) |=> acr_n == 24'h000000)
      else $error("zero N write not seen on output");
   a_prime_gate: assert property (                                // R12
      $rose(r.primed) |-> 32'($past(f.level)) >= 32'($past(r.chans)))
      else $error("reads enabled before channel count stored");
   a_no_early_pop: assert property (                              // R12
      (ce && !r.primed) |=> $stable(f.pop_data) || $past(f.flush))
      else $error("sample moved before priming");
   a_stop_done: assert property (                                 // R13
      (ce && r.run && r.stop_req && !r.start_req && r.st == DMA_IDLE)
      |=> !r.run && r.ist[INT_DONE] && r.m_htrans == HTRANS_IDLE)
      else $error("stop did not end run with done flag");
   a_addr_window: assert property (                               // R14
      (r.m_htrans[1] && r.first <= r.last)
      |-> r.m_haddr >= r.first && r.m_haddr <= r.last)
      else $error("fetch address outside buffer");

endmodule // hada_audio_dma
`default_nettype wire

/* File: dv/hada_mem_model.sv */
// Memory slave model on the fetch bus of the audio DMA.
// Assumes single-clock bus; each word holds its own byte address.
`timescale 1ns/100ps
`default_nettype none
module hada_mem_model import hada_pkg::*; (
   // System
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   input  wire logic        slow,
   input  wire logic [31:0] bad_a,
   // Fetch bus
   input  wire logic [31:0] m_haddr,
   input  wire logic [1:0]  m_htrans,
   output logic [31:0]      m_hrdata,
   output logic             m_hready,
   output logic             m_hresp
);
   logic        dp_v;
   logic [31:0] dp_a;
   logic [1:0]  wait_cnt;

   assign m_hready = (wait_cnt == 2'h0);
   // Error answer on the data beat of one chosen address
   assign m_hresp  = dp_v && m_hready && (dp_a == bad_a);
   // Outside a data beat the bus shows the inverse, never a stale word
   assign m_hrdata = (dp_v && m_hready) ? dp_a : ~dp_a;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         dp_v     <= 1'b0;
         dp_a     <= 32'h0;
         wait_cnt <= 2'h0;
      end else if (m_hready) begin
         dp_v     <= m_htrans[1];
         dp_a     <= m_haddr;
         wait_cnt <= (m_htrans[1] && slow) ? 2'h2 : 2'h0;
      end else begin
         wait_cnt <= wait_cnt - 2'h1;
      end
   end
endmodule // hada_mem_model
`default_nettype wire

/* File: dv/testbench.sv */
// Self-checking bench of the audio DMA with a memory model.
// Assumes the register map and bus timing of the design package.
`timescale 1ns/100ps
`default_nettype none
module testbench import hada_pkg::*; ;
   logic        clk_sys = 0, rst_n = 0, hsel = 0, hwrite = 0, aud_rd = 0;
   logic        slow = 0, no_fetch = 0, hreadyout, hresp, m_hready;
   logic        m_hresp, m_hwrite, aud_primed, irq;
   logic [1:0]  htrans = HTRANS_IDLE, m_htrans;
   logic [2:0]  m_hburst, m_hsize, exp_burst = HBURST_INCR;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, m_haddr, m_hrdata, aud_data;
   logic [31:0] exp_ma = 0, exp_s = 0, rv, bad_a = 0;
   logic [23:0] acr_n, acr_cts;
   int          fail_count = 0, check_count = 0, cyc = 0;

   always #2 clk_sys = ~clk_sys;

   hada_audio_dma hada_audio_dma_i (.clk_sys, .rst_n, .ce(1'b1), .hsel,
      .haddr, .htrans, .hwrite, .hsize(HSIZE_WORD), .hwdata,
      .hready(hreadyout), .hreadyout, .hresp, .hrdata, .m_haddr, .m_htrans,
      .m_hburst, .m_hsize, .m_hwrite, .m_hrdata, .m_hready, .m_hresp,
      .aud_rd, .aud_data, .aud_primed, .acr_n, .acr_cts, .irq);

   hada_mem_model hada_mem_model_i (.clk_sys, .rst_n, .slow, .bad_a,
      .m_haddr, .m_htrans, .m_hrdata, .m_hready, .m_hresp);

   task automatic wrap_up();
      $display("checks=%0d mismatches=%0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One single word transfer; read data lands in rv
   task automatic bus(input logic w, input logic [31:0] idx,
                      input logic [31:0] wd);
      haddr  <= {idx[29:0], 2'b00};
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      hsel   <= 1'b1;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      htrans <= HTRANS_IDLE;
      hsel   <= 1'b0;
      hwdata <= wd;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      rv = hrdata;
   endtask

   task automatic rdc(input logic [31:0] idx, input logic [31:0] e);
      bus(1'b0, idx, 32'h0);
      chk(rv, e);
      chk(32'(hresp), 32'h0);
   endtask

   task automatic poll(input int b);
      int n;
      n = 0;
      do begin
         bus(1'b0, IDX_INT_STAT, 32'h0);
         n++;
      end while (rv[b] !== 1'b1 && n < 100);
      chk(32'(rv[b]), 32'h1);
   endtask

   // One sample from the audio port, checked against e
   task automatic take(input logic [31:0] e);
      aud_rd <= 1'b1;
      @(posedge clk_sys);
      aud_rd <= 1'b0;
      @(posedge clk_sys);
      chk(aud_data, e);
   endtask

   // Fetch bus watcher: address order, burst kind, silence after stop
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         wrap_up();
      end
      if (rst_n && m_htrans[1] && m_hready) begin
         chk(m_haddr, exp_ma);
         chk(32'(m_hsize), 32'(HSIZE_WORD));
         chk(32'(m_hwrite), 32'h0);
         exp_ma = exp_ma + 32'h4;
         if (m_htrans == HTRANS_NONSEQ)
            chk(32'(m_hburst), 32'(exp_burst));
         if (no_fetch)
            chk(32'h1, 32'h0);
      end
   end

   // Init and start procedure for one buffer
   task automatic prog(input logic [31:0] first, input logic [31:0] words,
                       input logic [7:0] cfg, input logic [3:0] ch);
      bus(1'b1, IDX_ACR_N, 32'h0);
      bus(1'b1, IDX_ACR_CTS, 32'h0001_2345);
      bus(1'b1, IDX_BURST_CFG, {24'h0, cfg});
      bus(1'b1, IDX_THRESHOLD, 32'h0000_007E);
      bus(1'b1, IDX_CHANNELS, {28'h0, ch});
      bus(1'b1, IDX_FIRST, first);
      bus(1'b1, IDX_LAST, first + (words - 32'h1) * 32'h4);
      bus(1'b1, IDX_INT_STAT, 32'h0000_000F);
      exp_ma = first;
      exp_s  = first;
      bus(1'b1, IDX_CONTROL, 32'h0000_0001);
      chk(32'(acr_n), 32'h0);
      chk(32'(acr_cts), 32'h0001_2345);
   endtask

   task automatic t_reset();
      chk(32'(aud_primed), 32'h0);
      chk(32'(irq), 32'h0);
      rdc(IDX_BURST_CFG, {24'h0, CFG_RST});
      rdc(IDX_THRESHOLD, {24'h0, THR_RST});
      rdc(IDX_CHANNELS, {28'h0, CHAN_RST});
      rdc(32'h0012_36F0, 32'h0);
      bus(1'b1, IDX_THRESHOLD, 32'h0000_0155);
      rdc(IDX_THRESHOLD, 32'h0000_0055);
   endtask

   task automatic t_stereo();
      exp_burst = HBURST_INCR;
      prog(32'h0000_1000, 32'd512, 8'h00, 4'h2);
      poll(INT_FULL);
      rdc(IDX_STATUS, 32'h0003_0080);
      chk(32'(irq), 32'h0);
      bus(1'b1, IDX_INT_MASK, 32'h0000_0004);
      repeat (3) @(posedge clk_sys);
      chk(32'(irq), 32'h1);
      bus(1'b1, IDX_INT_STAT, 32'h0000_0004);
      bus(1'b1, IDX_ACR_N, 32'h0000_1800);
      repeat (3) @(posedge clk_sys);
      chk(32'(irq), 32'h0);
      chk(32'(acr_n), 32'h0000_1800);
      repeat (4) begin
         take(exp_s);
         exp_s = exp_s + 32'h4;
      end
   endtask

   task automatic t_stop();
      bus(1'b1, IDX_INT_MASK, 32'h0000_0001);
      bus(1'b1, IDX_CONTROL, 32'h0000_0002);
      poll(INT_DONE);
      no_fetch = 1'b1;
      chk(32'(irq), 32'h1);
      bus(1'b0, IDX_STATUS, 32'h0);
      chk(32'(rv[STAT_RUN]), 32'h0);
      chk(32'(rv[7:0]), 32'h0000_007C);
      repeat (124) begin
         take(exp_s);
         exp_s = exp_s + 32'h4;
      end
      take(exp_s - 32'h4);
      take(exp_s - 32'h4);
      poll(INT_EMPTY);
   endtask

   task automatic t_multi();
      no_fetch = 1'b0;
      slow <= 1'b1;
      exp_burst = HBURST_INCR4;
      prog(32'h0000_2000, 32'd16, 8'h02, 4'h8);
      repeat (2) @(posedge clk_sys);
      chk(32'(aud_primed), 32'h0);
      poll(INT_DONE);
      rdc(IDX_STATUS, 32'h0001_0010);
      repeat (16) begin
         take(exp_s);
         exp_s = exp_s + 32'h4;
      end
   endtask

   // Singles, INCR16, then INCR8 with an error beat
   task automatic t_modes();
      exp_burst = HBURST_SINGLE;
      prog(32'h0000_3000, 32'd4, 8'h01, 4'h2);
      poll(INT_DONE);
      take(exp_s);
      exp_burst = HBURST_INCR16;
      prog(32'h0000_4000, 32'd16, 8'h06, 4'h2);
      poll(INT_DONE);
      take(exp_s);
      bad_a = 32'h0000_5004;
      exp_burst = HBURST_INCR8;
      prog(32'h0000_5000, 32'd16, 8'h04, 4'h2);
      poll(INT_ERROR);
      poll(INT_DONE);
      rdc(IDX_STATUS, 32'h0000_0001);
   endtask

   initial begin
      repeat (16) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      t_reset();
      t_stereo();
      t_stop();
      t_multi();
      t_modes();
      wrap_up();
   end
endmodule // testbench
`default_nettype wire
